// ==== inc/mrtc_consts.vh ====
// constants for the multichip routing table host controller
// assumes a 32-bit register port on the distributor with word addresses
`ifndef MRTC_CONSTS_VH
`define MRTC_CONSTS_VH
// register word addresses of the distributor (map of the device outside)
`define MRTC_ADDR_CTRL 12'h000
`define MRTC_ADDR_OWN 12'h004
`define MRTC_ADDR_STAT 12'h008
`define MRTC_ADDR_CFGID 12'h00C
`define MRTC_ADDR_ENTRY0 12'h010
// field positions
`define MRTC_OWN_PUP_BIT 31
`define MRTC_CTRL_RWP_BIT 31
`define MRTC_CTRL_GRP_MASK 32'h00000007
`define MRTC_CFG_LCA_BIT 0
`define MRTC_ENT_ONLINE_BIT 0
`define MRTC_ENT_MIN_LSB 1
`define MRTC_ENT_CNT_LSB 7
`define MRTC_ENT_ADDR_LSB 16
`define MRTC_STAT_RTS_LSB 0
`define MRTC_RTS_CONSISTENT 2'h2
// spi block arithmetic
`define MRTC_SPI_BLK 10'h020
// power state codes
`define MRTC_PST_RUN 4'h0
`define MRTC_PST_CONFIG 4'h9
`define MRTC_PST_OFF 4'h8
// poll limit (cycles between status reads is one access)
`define MRTC_POLL_MAX 16'hFFFF
`endif

// ==== design/mrtc_bus_port.v ====
// register access engine: one read or write on the distributor port
// assumes the device answers with reg_ack some cycles after reg_req
`timescale 1ns/1ps
module mrtc_bus_port (
	input wire sys_clk, // system clock
	input wire resetn, // async reset, active low
	input wire go, // start one access, pulse
	input wire go_wr, // 1 write, 0 read
	input wire [11:0] go_addr, // word address
	input wire [31:0] go_wdata, // write data
	output reg reg_req_ff, // request to device
	output reg reg_wr_ff, // write strobe
	output reg [11:0] reg_addr_ff, // address to device
	output reg [31:0] reg_wdata_ff, // write data to device
	input wire reg_ack, // device completion
	input wire [31:0] reg_rdata, // device read data
	output reg done_ff, // access finished, pulse
	output reg [31:0] rdata_ff // captured read data
);
	// hold request until the device acknowledges it
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_req_ff <= 1'b0;
			reg_wr_ff <= 1'b0;
			reg_addr_ff <= 12'h000;
			reg_wdata_ff <= 32'h00000000;
			done_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
		end else begin
			done_ff <= 1'b0;
			if (reg_req_ff && reg_ack) begin
				reg_req_ff <= 1'b0;
				done_ff <= 1'b1;
				rdata_ff <= reg_rdata;
			end else if (go && !reg_req_ff) begin
				reg_req_ff <= 1'b1;
				reg_wr_ff <= go_wr;
				reg_addr_ff <= go_addr;
				reg_wdata_ff <= go_wdata;
			end
		end
	end
endmodule

// ==== design/mrtc_host.v ====
// host controller for a multichip routing table: owner change,
// chip connect and chip isolation through the power channel
// assumes a distributor register port (req/ack) and a p-channel
`timescale 1ns/1ps
`include "mrtc_consts.vh"
module mrtc_host (
	input wire sys_clk, // system clock, 200 MHz
	input wire resetn, // async reset, active low
	input wire cmd_valid, // user command strobe, pulse
	input wire [1:0] cmd_op, // 0 owner,1 connect,2 isolate,3 restore
	input wire [3:0] cmd_chip, // target chip number
	input wire [9:0] cmd_first_id, // first spi id of chip
	input wire [9:0] cmd_last_id, // last spi id of chip
	input wire [15:0] cmd_fwd_addr, // forwarding address
	input wire [31:0] cmd_restore_data, // saved entry value to restore
	output reg busy_ff, // command in progress
	output reg done_ff, // command finished, pulse
	output reg fail_ff, // command failed, valid with done
	output reg reg_req_ff, // register access request
	output reg reg_wr_ff, // register write
	output reg [11:0] reg_addr_ff, // register word address
	output reg [31:0] reg_wdata_ff, // register write data
	input wire reg_ack, // register access complete
	input wire [31:0] reg_rdata, // register read data
	output reg [3:0] pstate_ff, // requested power state
	output reg preq_ff, // power request
	input wire paccept, // power request accepted
	input wire pdeny, // power request denied
	input wire pactive // device activity
);
	localparam S_IDLE = 4'h0;
	localparam S_RWP = 4'h1;
	localparam S_WR = 4'h2;
	localparam S_POLL = 4'h3;
	localparam S_CHK = 4'h4;
	localparam S_STAT = 4'h5;
	localparam S_PREQ = 4'h6;
	localparam S_PWAIT = 4'h7;
	localparam S_DONE = 4'h8;
	localparam S_ACC = 4'h9;

	// first spi block: (first - 32) / 32
	function [5:0] blk_min;
		input [9:0] id;
		reg [9:0] t;
		begin
			t = id - `MRTC_SPI_BLK;
			blk_min = {1'b0, t[9:5]};
		end
	endfunction
	// block count: (last - first + 1) / 32
	function [8:0] blk_cnt;
		input [9:0] lo;
		input [9:0] hi;
		reg [9:0] t;
		begin
			t = hi - lo + 10'h001;
			blk_cnt = {4'h0, t[9:5]};
		end
	endfunction

	reg [3:0] st_ff, nxt_st;
	reg [3:0] ret_ff, nxt_ret;
	reg [1:0] op_ff;
	reg [3:0] chip_ff;
	reg [31:0] val_ff;
	reg [15:0] poll_ff, nxt_poll;
	reg go, go_wr;
	reg [11:0] go_addr;
	reg [31:0] go_wdata;
	reg nxt_done, nxt_fail, nxt_preq;
	reg [3:0] nxt_pst;
	wire bp_done;
	wire [31:0] bp_rdata;
	wire bp_req, bp_wr;
	wire [11:0] bp_addr;
	wire [31:0] bp_wdata;
	wire [11:0] ent_addr = `MRTC_ADDR_ENTRY0 + {6'h00, chip_ff, 2'h0};

	mrtc_bus_port u_bp (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.go(go),
		.go_wr(go_wr),
		.go_addr(go_addr),
		.go_wdata(go_wdata),
		.reg_req_ff(bp_req),
		.reg_wr_ff(bp_wr),
		.reg_addr_ff(bp_addr),
		.reg_wdata_ff(bp_wdata),
		.reg_ack(reg_ack),
		.reg_rdata(reg_rdata),
		.done_ff(bp_done),
		.rdata_ff(bp_rdata)
	);

	// latch command fields; build single-write entry value
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			op_ff <= 2'h0;
			chip_ff <= 4'h0;
			val_ff <= 32'h00000000;
		end else if (st_ff == S_IDLE && cmd_valid) begin
			op_ff <= cmd_op;
			chip_ff <= cmd_chip;
			if (cmd_op == 2'h3)
				val_ff <= cmd_restore_data;
			else if (cmd_op == 2'h0)
				val_ff <= {28'h0000000, cmd_chip};
			else
				val_ff <= {cmd_fwd_addr,
					blk_cnt(cmd_first_id, cmd_last_id),
					blk_min(cmd_first_id), 1'b1};
		end
	end

	// sequencer
	always @* begin
		nxt_st = st_ff;
		nxt_ret = ret_ff;
		nxt_poll = poll_ff;
		nxt_done = 1'b0;
		nxt_fail = fail_ff;
		nxt_preq = preq_ff;
		nxt_pst = pstate_ff;
		go = 1'b0;
		go_wr = 1'b0;
		go_addr = `MRTC_ADDR_CTRL;
		go_wdata = val_ff;
		case (st_ff)
		S_IDLE: begin
			if (cmd_valid) begin
				nxt_fail = 1'b0;
				nxt_poll = 16'h0000;
				if (cmd_op == 2'h2)
					nxt_st = S_PREQ;
				else if (cmd_op == 2'h3)
					nxt_st = S_WR;
				else if (pstate_ff == `MRTC_PST_CONFIG) begin
					// owner or entry writes are refused while in config (state 9), not while off
					nxt_fail = 1'b1;
					nxt_st = S_DONE;
				end else
					nxt_st = S_RWP;
			end
		end
		S_RWP: begin
			// read control: groups off and no write pending
			go = 1'b1;
			go_addr = `MRTC_ADDR_CTRL;
			nxt_ret = S_RWP;
			nxt_st = S_ACC;
		end
		S_WR: begin
			go = 1'b1;
			go_wr = 1'b1;
			go_addr = (op_ff == 2'h0) ? `MRTC_ADDR_OWN : ent_addr;
			nxt_ret = S_WR;
			nxt_st = S_ACC;
		end
		S_POLL: begin
			go = 1'b1;
			go_addr = `MRTC_ADDR_OWN;
			nxt_ret = S_POLL;
			nxt_st = S_ACC;
		end
		S_CHK: begin
			go = 1'b1;
			go_addr = ent_addr;
			nxt_ret = S_CHK;
			nxt_st = S_ACC;
		end
		S_STAT: begin
			go = 1'b1;
			go_addr = `MRTC_ADDR_STAT;
			nxt_ret = S_STAT;
			nxt_st = S_ACC;
		end
		S_ACC: begin
			if (bp_done) begin
				nxt_poll = poll_ff + 16'h0001;
				case (ret_ff)
				S_RWP: begin
					if (bp_rdata[`MRTC_CTRL_RWP_BIT] ||
						(bp_rdata & `MRTC_CTRL_GRP_MASK) != 32'h0)
						nxt_st = S_RWP;
					else
						nxt_st = S_WR;
				end
				S_WR: nxt_st = (op_ff == 2'h3) ? S_DONE : S_POLL;
				S_POLL: begin
					if (bp_rdata[`MRTC_OWN_PUP_BIT])
						nxt_st = S_POLL;
					else if (op_ff == 2'h1)
						nxt_st = S_CHK;
					else
						nxt_st = S_DONE;
				end
				S_CHK: begin
					if (!bp_rdata[`MRTC_ENT_ONLINE_BIT]) begin
						nxt_fail = 1'b1;
						nxt_st = S_DONE;
					end else
						nxt_st = S_STAT;
				end
				S_STAT: begin
					if (bp_rdata[1:0] != `MRTC_RTS_CONSISTENT)
						nxt_fail = 1'b1;
					nxt_st = S_DONE;
				end
				default: nxt_st = S_DONE;
				endcase
				if (poll_ff == `MRTC_POLL_MAX) begin
					nxt_fail = 1'b1;
					nxt_st = S_DONE;
				end
			end
		end
		S_PREQ: begin
			// request config, later off, from the power channel
			nxt_preq = 1'b1;
			nxt_pst = (pstate_ff == `MRTC_PST_CONFIG) ?
				`MRTC_PST_OFF : `MRTC_PST_CONFIG;
			nxt_st = S_PWAIT;
		end
		S_PWAIT: begin
			if (paccept) begin
				nxt_preq = 1'b0;
				if (pstate_ff == `MRTC_PST_CONFIG && !pactive)
					nxt_st = S_PREQ;
				else if (pstate_ff == `MRTC_PST_CONFIG) begin
					nxt_pst = `MRTC_PST_RUN;
					nxt_fail = 1'b1;
					nxt_st = S_DONE;
				end else
					nxt_st = S_DONE;
			end else if (pdeny) begin
				nxt_preq = 1'b0;
				nxt_fail = 1'b1;
				if (pstate_ff == `MRTC_PST_OFF)
					nxt_pst = `MRTC_PST_CONFIG;
				else
					nxt_pst = `MRTC_PST_RUN;
				nxt_st = S_DONE;
			end else if (pactive && pstate_ff == `MRTC_PST_OFF) begin
				nxt_preq = 1'b0;
				nxt_pst = `MRTC_PST_CONFIG;
				nxt_fail = 1'b1;
				nxt_st = S_DONE;
			end
		end
		S_DONE: begin
			nxt_done = 1'b1;
			nxt_st = S_IDLE;
		end
		default: nxt_st = S_IDLE;
		endcase
	end

	// state and output registers
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_ff <= S_IDLE;
			ret_ff <= S_IDLE;
			poll_ff <= 16'h0000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
			preq_ff <= 1'b0;
			pstate_ff <= `MRTC_PST_RUN;
		end else begin
			st_ff <= nxt_st;
			ret_ff <= nxt_ret;
			poll_ff <= nxt_poll;
			busy_ff <= (nxt_st != S_IDLE);
			done_ff <= nxt_done;
			fail_ff <= nxt_fail;
			preq_ff <= nxt_preq;
			pstate_ff <= nxt_pst;
		end
	end

	// register port outputs passed straight through from the access engine, not registered
	always @* begin
		reg_req_ff = bp_req;
		reg_wr_ff = bp_wr;
		reg_addr_ff = bp_addr;
		reg_wdata_ff = bp_wdata;
	end
endmodule

// ==== testbench/mrtc_dev_model.sv ====
// model of the distributor: register port and power channel
// assumes one access at a time, request held until reg_ack
`timescale 1ns/1ps
`include "mrtc_consts.vh"
module mrtc_dev_model (
	input logic sys_clk, // clock
	input logic resetn, // reset, low
	input logic reg_req_ff, // request
	input logic reg_wr_ff, // write
	input logic [11:0] reg_addr_ff, // address
	input logic [31:0] reg_wdata_ff, // write data
	output logic reg_ack, // answer pulse
	output logic [31:0] reg_rdata, // read data
	input logic [3:0] pstate_ff, // wanted state
	input logic preq_ff, // power request
	output logic paccept, // accept pulse
	output logic pdeny, // deny pulse
	output logic pactive, // activity
	input logic reject, // refuse entry writes
	input logic deny, // not idle
	input logic act // messages pending
);
	logic [31:0] ent_ff [0:15];
	logic [3:0] own_ff, ps_ff;
	logic [1:0] pup_ff, rwp_ff, wc_ff, pc_ff;
	logic [5:0] ix;
	assign ix = reg_addr_ff[7:2] - 6'h04;
	assign pactive = act;
	// register port, answers on the third cycle of a request
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			own_ff <= 4'h0;
			pup_ff <= 2'h0;
			rwp_ff <= 2'h2;
			wc_ff <= 2'h0;
			reg_ack <= 1'b0;
			reg_rdata <= 32'h0;
		end else if (reg_req_ff && !reg_ack && wc_ff != 2'h2) begin
			wc_ff <= wc_ff + 2'h1;
			reg_rdata <= ~reg_rdata;
		end else if (reg_req_ff && !reg_ack) begin
			wc_ff <= 2'h0;
			reg_ack <= 1'b1;
			case (reg_addr_ff)
			`MRTC_ADDR_CTRL: begin
				reg_rdata <= {rwp_ff != 2'h0, 31'h0};
				rwp_ff <= rwp_ff - {1'b0, rwp_ff != 2'h0};
			end
			`MRTC_ADDR_OWN: begin
				reg_rdata <= {pup_ff != 2'h0, 27'h0, own_ff};
				pup_ff <= reg_wr_ff ? 2'h3 : pup_ff - {1'b0, pup_ff != 2'h0};
				if (reg_wr_ff)
					own_ff <= reg_wdata_ff[3:0];
			end
			`MRTC_ADDR_STAT: reg_rdata <= pup_ff != 0 ? 32'h1 : 32'h2;
			`MRTC_ADDR_CFGID: reg_rdata <= 32'h0;
			default: begin
				reg_rdata <= ent_ff[ix[3:0]];
				if (reg_wr_ff)
					pup_ff <= 2'h3;
				if (reg_wr_ff)
					ent_ff[ix[3:0]] <= reg_wdata_ff & {31'h7FFFFFFF, !reject};
			end
			endcase
		end else begin
			reg_ack <= 1'b0;
			reg_rdata <= ~reg_rdata; // released data is not held
		end
	end
	// power channel, one answer per new request
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pc_ff <= 2'h0;
			ps_ff <= 4'h0;
			paccept <= 1'b0;
			pdeny <= 1'b0;
		end else begin
			ps_ff <= pstate_ff;
			pc_ff <= (!preq_ff || pstate_ff != ps_ff) ? 2'h0 :
				pc_ff + {1'b0, pc_ff != 2'h3};
			paccept <= preq_ff && pc_ff == 2'h2 && !deny;
			pdeny <= preq_ff && pc_ff == 2'h2 && deny;
		end
	end
endmodule

// ==== testbench/mrtc_host_sva.sv ====
// checker for the host controller's register and power handshakes
// assumes it is bound to the controller and sees only its ports
`timescale 1ns/1ps
`include "mrtc_consts.vh"
module mrtc_host_sva (
	input logic sys_clk, // clock
	input logic resetn, // reset, low
	input logic cmd_valid, // command
	input logic [1:0] cmd_op, // op code
	input logic busy_ff, // busy
	input logic done_ff, // done
	input logic fail_ff, // failed
	input logic reg_req_ff, // request
	input logic reg_wr_ff, // write
	input logic [11:0] reg_addr_ff, // address
	input logic [31:0] reg_wdata_ff, // write data
	input logic reg_ack, // answer
	input logic [31:0] reg_rdata, // read data
	input logic [3:0] pstate_ff, // state
	input logic preq_ff, // power request
	input logic paccept, // accept
	input logic pdeny, // deny
	input logic pactive // activity
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [1:0] op_q;
	// operation of the command in flight, for the restore exception
	always @(posedge sys_clk or negedge resetn)
		if (!resetn)
			op_q <= 2'h0;
		else if (cmd_valid && !busy_ff)
			op_q <= cmd_op;
	AST_REQ_HOLD: assert property (reg_req_ff && !reg_ack |=> reg_req_ff
		&& $stable(reg_addr_ff) && $stable(reg_wdata_ff)) else $error("req moved");
	AST_DONE_ONE: assert property (done_ff |=> !done_ff)
		else $error("done longer than one cycle");
	AST_START: assert property (cmd_valid && !busy_ff && !cmd_op[1]
		&& pstate_ff != `MRTC_PST_CONFIG
		|-> ##2 reg_req_ff && !reg_wr_ff && reg_addr_ff == `MRTC_ADDR_CTRL)
		else $error("command did not start with control read");
	AST_RWP_POLL: assert property (reg_ack && !reg_wr_ff && reg_rdata[31]
		&& reg_addr_ff == `MRTC_ADDR_CTRL |-> ##[1:6] reg_req_ff
		&& reg_addr_ff == `MRTC_ADDR_CTRL) else $error("write pending ignored");
	AST_PUP_POLL: assert property (reg_ack && !reg_wr_ff && reg_rdata[31]
		&& reg_addr_ff == `MRTC_ADDR_OWN |-> ##[1:6] reg_req_ff
		&& reg_addr_ff == `MRTC_ADDR_OWN) else $error("update pending ignored");
	AST_REJECT: assert property (reg_ack && !reg_wr_ff && !reg_rdata[0]
		&& reg_addr_ff >= `MRTC_ADDR_ENTRY0 |-> ##[1:6] done_ff && fail_ff)
		else $error("offline entry not failed");
	AST_CFG_FIRST: assert property ($rose(preq_ff) && pstate_ff != 4'h8
		|-> pstate_ff == `MRTC_PST_CONFIG) else $error("first request not config");
	AST_TO_OFF: assert property (preq_ff && paccept && !pactive
		&& pstate_ff == `MRTC_PST_CONFIG |-> ##[1:4] pstate_ff == `MRTC_PST_OFF)
		else $error("off not requested after config");
	AST_ACT_RUN: assert property (preq_ff && paccept && pactive
		&& pstate_ff == `MRTC_PST_CONFIG |-> ##[1:4] pstate_ff == `MRTC_PST_RUN)
		else $error("no return to run on activity");
	AST_DENY: assert property (preq_ff && pdeny |-> ##[1:6] done_ff && fail_ff)
		else $error("deny not reported");
	AST_NO_WR_CFG: assert property (pstate_ff == `MRTC_PST_CONFIG
		&& op_q != 2'h3 |-> !(reg_req_ff && reg_wr_ff))
		else $error("write in config");
endmodule
bind mrtc_host mrtc_host_sva chk_u (.*);

// ==== testbench/tb_mrtc_host.sv ====
// testbench: routing table host controller against a device model
// assumes the model answers register and power requests promptly
`timescale 1ns/1ps
module tb_mrtc_host;
	logic sys_clk = 0, resetn = 0, cmd_valid = 0;
	logic [1:0] cmd_op = 0;
	logic [3:0] cmd_chip = 0, pstate_ff;
	logic [9:0] cmd_first_id = 0, cmd_last_id = 0;
	logic [15:0] cmd_fwd_addr = 0;
	logic [31:0] cmd_restore_data = 0, reg_wdata_ff, reg_rdata;
	logic busy_ff, done_ff, fail_ff, reg_req_ff, reg_wr_ff, reg_ack;
	logic [11:0] reg_addr_ff;
	logic preq_ff, paccept, pdeny, pactive, reject = 0, deny = 0, act = 0;
	int fail_count = 0, n_checks = 0;
	mrtc_host dut_u (.*);
	mrtc_dev_model m_u (.*);
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one command, waits for its done pulse
	task run(input logic [1:0] op, input logic [3:0] ch,
		input logic [9:0] f, input logic [9:0] l, input logic [31:0] d);
		@(negedge sys_clk);
		cmd_op = op;
		cmd_chip = ch;
		cmd_first_id = f;
		cmd_last_id = l;
		cmd_fwd_addr = d[15:0];
		cmd_restore_data = d;
		cmd_valid = 1;
		@(negedge sys_clk);
		cmd_valid = 0;
		repeat (4000) if (done_ff !== 1'b1) @(negedge sys_clk);
		chk(done_ff, 32'h1);
	endtask
	function logic [31:0] ent(input logic [9:0] f, input logic [9:0] l,
		input logic [15:0] a);
		return {a, 9'((l - f + 10'h001) / 10'h020),
			6'((f - 10'h020) / 10'h020), 1'b1};
	endfunction
	// watchdog
	initial begin
		#100000;
		fail_count++;
		stop_test;
	end
	// test sequence
	initial begin
		repeat (8) @(negedge sys_clk);
		resetn = 1;
		run(2'h0, 4'h5, 10'h000, 10'h000, 32'h0);
		chk(m_u.own_ff, 32'h5);
		chk(m_u.pup_ff, 32'h0);
		chk(m_u.rwp_ff, 32'h0);
		chk(fail_ff, 32'h0);
		$display("test owner change ended");
		run(2'h1, 4'h2, 10'h060, 10'h09F, 32'hA5C3);
		chk(m_u.ent_ff[2], ent(10'h060, 10'h09F, 16'hA5C3));
		chk(fail_ff, 32'h0);
		reject = 1;
		run(2'h1, 4'h3, 10'h0A0, 10'h0DF, 32'h0077);
		chk(fail_ff, 32'h1);
		reject = 0;
		$display("test connect ended");
		run(2'h3, 4'h4, 10'h000, 10'h000, 32'h12340103);
		chk(m_u.ent_ff[4], 32'h12340103);
		$display("test restore ended");
		deny = 1;
		run(2'h2, 4'h1, 10'h000, 10'h000, 32'h0);
		chk(fail_ff, 32'h1);
		chk(pstate_ff, 32'h0);
		deny = 0;
		act = 1;
		run(2'h2, 4'h1, 10'h000, 10'h000, 32'h0);
		chk(fail_ff, 32'h1);
		chk(pstate_ff, 32'h0);
		act = 0;
		run(2'h2, 4'h1, 10'h000, 10'h000, 32'h0);
		chk(fail_ff, 32'h0);
		chk(pstate_ff, 32'h8);
		// activity while off is requested sends the chip back to config
		fork
			run(2'h2, 4'h1, 10'h000, 10'h000, 32'h0);
			begin
				wait (pstate_ff == 4'h9);
				wait (pstate_ff == 4'h8);
				@(negedge sys_clk);
				act = 1;
			end
		join
		chk(fail_ff, 32'h1);
		chk(pstate_ff, 32'h9);
		act = 0;
		run(2'h0, 4'h7, 10'h000, 10'h000, 32'h0);
		chk(fail_ff, 32'h1);
		chk(m_u.own_ff, 32'h5);
		$display("test isolate ended");
		stop_test;
	end
endmodule
